// ---- design/wppd_gate.sv ----
// command gate for the shared protect / power-down pin
// assumes the host-side decoder presents one command per cmdValid pulse
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - pin has one role only: write protect or power-down.
// - role changes only through the pin role select command or the power-on reload.
// - stored role survives every reset; power-on reloads the factory role.
// - in protect role with pin active, destructive commands are refused.
// - refused commands end with status 51H and error 04H.
// - non-destructive commands run normally while protected.
// - protection covers the whole address space.
// - in power-down role, pin during a command aborts it and sleeps.
// - after pin power-down no command is taken until reset.
// - soft or hard reset leaves power-down, pin released by host.
// - first power-up reports busy for up to seven seconds.
// - first power-up busy happens only once in the device life.
// - four zones, each read-only or hidden, off by default.
// - enabled zones need the matching password before writes; hidden zones also before reads.
// - factory role is write protect.
module wppd_gate #(
   parameter longint FIRST_BUSY_CYCLES = wppd_pkg::FIRST_BUSY_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic softReset,
   input wire logic powerOn,
   input wire logic initDoneStrap,
   // pin
   input wire logic protect_or_sleep_pin_n,
   // command from host decoder
   input wire logic cmdValid,
   input wire logic [7:0] cmdCode,
   input wire logic [7:0] cmdFeature,
   input wire logic [31:0] cmdLba,
   // backend execution
   input wire logic execDone,
   input wire logic initDone,
   // zone setup
   input wire logic zoneWrite,
   input wire logic [1:0] zoneIdx,
   input wire logic zoneEnable,
   input wire logic zoneHidden,
   input wire logic [31:0] zoneStart,
   input wire logic [31:0] zoneEnd,
   input wire logic [31:0] zonePassword,
   input wire logic pwdValid,
   input wire logic [31:0] pwdValue,
   // answers
   output logic busy,
   output logic execStart,
   output logic execAbort,
   output logic cmdDone,
   output logic [7:0] statusOut,
   output logic [7:0] errorOut,
   output logic sleeping,
   output logic roleSleep,
   output logic firstInit
);
   wppd_pkg::wppd_state_e state;
   logic pinMeta, pinSync;
   logic role, initFlag;
   logic isWrite, destructive, roleCmd;
   logic [31:0] busyCnt;
   logic [3:0] zoneEn, zoneHid, zoneUnlocked;
   logic [31:0] zLo [4], zHi [4], zPwd [4];
   logic [3:0] zoneHit;
   logic zoneBlockRd, zoneBlockWr;

   // ----------------------------------------
   // pin synchroniser, active low pin
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
      end else begin
         pinMeta <= ~protect_or_sleep_pin_n;
         pinSync <= pinMeta;
      end
   end

   // ----------------------------------------
   // persistent role and init flag
   // ----------------------------------------
   assign roleCmd = cmdValid && state == wppd_pkg::ST_IDLE && cmdCode == wppd_pkg::CMD_ROLE_SELECT;

   wppd_nv_bit u_role (
      .sys_clk(sys_clk),
      .wrEn(roleCmd),
      .wrData(cmdFeature == wppd_pkg::FEAT_POWERDOWN),
      .loadEn(powerOn),
      .loadData(wppd_pkg::ROLE_FACTORY),
      .rdData(role)
   );

   wppd_nv_bit u_init (
      .sys_clk(sys_clk),
      .wrEn(state == wppd_pkg::ST_FIRST_BUSY && (initDone || busyCnt == 32'h0)),
      .wrData(1'b1),
      .loadEn(powerOn),
      .loadData(initDoneStrap),
      .rdData(initFlag)
   );

   // ----------------------------------------
   // command classification
   // ----------------------------------------
   always_comb begin
      destructive = 1'b0;
      case (cmdCode)
         wppd_pkg::CMD_ERASE_SECTOR, wppd_pkg::CMD_FORMAT_TRACK,
         wppd_pkg::CMD_WRITE_DMA0, wppd_pkg::CMD_WRITE_DMA1,
         wppd_pkg::CMD_WRITE_MULT, wppd_pkg::CMD_WRITE_SEC0,
         wppd_pkg::CMD_WRITE_SEC1, wppd_pkg::CMD_WRITE_VERIFY: destructive = 1'b1;
         default: destructive = 1'b0;
      endcase
   end
   assign isWrite = destructive;

   // ----------------------------------------
   // protection zones
   // ----------------------------------------
   genvar gz;
   generate
      for (gz = 0; gz < wppd_pkg::ZONES; gz++) begin : g_zone
         always_ff @(posedge sys_clk) begin
            if (!resetn) begin
               zoneUnlocked[gz] <= 1'b0;
            end else if (zoneWrite && zoneIdx == gz[1:0]) begin
               zoneUnlocked[gz] <= 1'b0;
            end else if (pwdValid && pwdValue == zPwd[gz]) begin
               zoneUnlocked[gz] <= 1'b1;
            end
         end
         // zone setup kept across resets, disabled at power-on
         always_ff @(posedge sys_clk) begin
            if (powerOn) begin
               zoneEn[gz] <= 1'b0;
               zoneHid[gz] <= 1'b0;
               zLo[gz] <= 32'h0;
               zHi[gz] <= 32'h0;
               zPwd[gz] <= 32'h0;
            end else if (zoneWrite && zoneIdx == gz[1:0]) begin
               zoneEn[gz] <= zoneEnable;
               zoneHid[gz] <= zoneHidden;
               zLo[gz] <= zoneStart;
               zHi[gz] <= zoneEnd;
               zPwd[gz] <= zonePassword;
            end
         end
         assign zoneHit[gz] = zoneEn[gz] && !zoneUnlocked[gz] &&
                              cmdLba >= zLo[gz] && cmdLba <= zHi[gz];
      end
   endgenerate
   assign zoneBlockWr = |zoneHit;
   assign zoneBlockRd = |(zoneHit & zoneHid);

   // ----------------------------------------
   // command sequencer
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn || softReset) begin
         // first busy again only while the one-time init is still owed
         state <= initFlag ? wppd_pkg::ST_IDLE : wppd_pkg::ST_FIRST_BUSY;
         busyCnt <= FIRST_BUSY_CYCLES[31:0];
         execStart <= 1'b0;
         execAbort <= 1'b0;
         cmdDone <= 1'b0;
         statusOut <= wppd_pkg::OK_STATUS;
         errorOut <= wppd_pkg::OK_ERROR;
      end else begin
         execStart <= 1'b0;
         execAbort <= 1'b0;
         cmdDone <= 1'b0;
         case (state)
            wppd_pkg::ST_FIRST_BUSY: begin
               if (initFlag) begin
                  state <= wppd_pkg::ST_IDLE;
               end else if (initDone || busyCnt == 32'h0) begin
                  state <= wppd_pkg::ST_IDLE;
               end else begin
                  busyCnt <= busyCnt - 32'h1;
               end
            end
            wppd_pkg::ST_IDLE: begin
               if (cmdValid) begin
                  if (roleCmd) begin
                     cmdDone <= 1'b1;
                     statusOut <= wppd_pkg::OK_STATUS;
                     errorOut <= wppd_pkg::OK_ERROR;
                  end else if ((!role && pinSync && isWrite) ||
                               (isWrite && zoneBlockWr) || zoneBlockRd) begin
                     cmdDone <= 1'b1;
                     statusOut <= wppd_pkg::REFUSE_STATUS;
                     errorOut <= wppd_pkg::REFUSE_ERROR;
                  end else begin
                     execStart <= 1'b1;
                     state <= wppd_pkg::ST_RUN;
                  end
               end
            end
            wppd_pkg::ST_RUN: begin
               if (role && pinSync) begin
                  execAbort <= 1'b1;
                  state <= wppd_pkg::ST_SLEEP;
               end else if (execDone) begin
                  cmdDone <= 1'b1;
                  statusOut <= wppd_pkg::OK_STATUS;
                  errorOut <= wppd_pkg::OK_ERROR;
                  state <= wppd_pkg::ST_IDLE;
               end
            end
            wppd_pkg::ST_SLEEP: begin
               state <= wppd_pkg::ST_SLEEP;
            end
            default: state <= wppd_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // registered status outputs
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         busy <= 1'b1;
         sleeping <= 1'b0;
         roleSleep <= wppd_pkg::ROLE_FACTORY;
         firstInit <= 1'b0;
      end else begin
         busy <= state != wppd_pkg::ST_IDLE;
         sleeping <= state == wppd_pkg::ST_SLEEP;
         roleSleep <= role;
         firstInit <= state == wppd_pkg::ST_FIRST_BUSY;
      end
   end
endmodule // wppd_gate
`default_nettype wire

// ---- design/wppd_pkg.sv ----
// package for the protect / power-down command gate
// assumes a 250 MHz sys_clk and ATA command codes from the host decoder
package wppd_pkg;
   localparam int CLK_MHZ = 250;
   // first power-up busy time
   localparam int FIRST_BUSY_MS = 7000;
   localparam longint FIRST_BUSY_CYCLES = longint'(FIRST_BUSY_MS) * 1000 * CLK_MHZ;
   // refused command answer
   localparam logic [7:0] REFUSE_STATUS = 8'h51;
   localparam logic [7:0] REFUSE_ERROR = 8'h04;
   localparam logic [7:0] OK_STATUS = 8'h50;
   localparam logic [7:0] OK_ERROR = 8'h00;
   // command codes
   localparam logic [7:0] CMD_ROLE_SELECT = 8'h8B;
   localparam logic [7:0] CMD_ERASE_SECTOR = 8'hC0;
   localparam logic [7:0] CMD_FORMAT_TRACK = 8'h50;
   localparam logic [7:0] CMD_WRITE_DMA0 = 8'hCA;
   localparam logic [7:0] CMD_WRITE_DMA1 = 8'hCB;
   localparam logic [7:0] CMD_WRITE_MULT = 8'hC5;
   localparam logic [7:0] CMD_WRITE_SEC0 = 8'h30;
   localparam logic [7:0] CMD_WRITE_SEC1 = 8'h31;
   localparam logic [7:0] CMD_WRITE_VERIFY = 8'h3C;
   // feature value choosing the power-down role
   localparam logic [7:0] FEAT_POWERDOWN = 8'h01;
   localparam logic [7:0] FEAT_PROTECT = 8'h00;
   // zones
   localparam int ZONES = 4;
   localparam int PWD_W = 32;
   // role: 0 = write protect (factory), 1 = power-down
   localparam logic ROLE_FACTORY = 1'b0;
   typedef enum logic [2:0] {ST_FIRST_BUSY, ST_IDLE, ST_RUN, ST_DONE, ST_SLEEP} wppd_state_e;
endpackage

// ---- design/wppd_nv_bit.sv ----
// non-volatile style storage for the pin role and one-time init flag
// assumes storage contents survive resetn; power-on value comes from loadData (factory role constant or init strap input)
`timescale 1ns/10ps
`default_nettype none
module wppd_nv_bit (
   // clock
   input wire logic sys_clk,
   // write port
   input wire logic wrEn,
   input wire logic wrData,
   // power-on contents
   input wire logic loadEn,
   input wire logic loadData,
   // read
   output logic rdData
);
   // no reset on purpose: content outlives every reset
   always_ff @(posedge sys_clk) begin
      if (loadEn) begin
         rdData <= loadData;
      end else if (wrEn) begin
         rdData <= wrData;
      end
   end
endmodule // wppd_nv_bit
`default_nettype wire

// ---- testbench/wppd_gate_asserts.sv ----
// checker for the protect / power-down gate outputs
// assumes it is bound onto wppd_gate
`timescale 1ns/10ps
`default_nettype none
module wppd_gate_asserts (
   // clock and resets
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic softReset,
   // inputs
   input wire logic protect_or_sleep_pin_n,
   input wire logic cmdValid,
   input wire logic [7:0] cmdCode,
   // outputs
   input wire logic busy,
   input wire logic execStart,
   input wire logic cmdDone,
   input wire logic [7:0] statusOut,
   input wire logic [7:0] errorOut,
   input wire logic sleeping,
   input wire logic roleSleep,
   input wire logic firstInit
);
   // ----
   // checks
   // ----
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic destr, pinLow, cause, take;
   assign destr = cmdCode inside {8'hC0, 8'h50, 8'hCA, 8'hCB, 8'hC5, 8'h30, 8'h31, 8'h3C};
   assign pinLow = !protect_or_sleep_pin_n;
   assign cause = (cmdValid && cmdCode == 8'h8B) || !resetn || softReset;
   assign take = cmdValid && !busy && !sleeping && !roleSleep;
   a_refuse_code: assert property (
      take && destr && pinLow && $past(pinLow, 1) && $past(pinLow, 2) && $past(pinLow, 3)
      |=> cmdDone && !execStart && statusOut == 8'h51 && errorOut == 8'h04)
      else $error("destructive command not refused");
   a_free_run: assert property (
      take && !destr && cmdCode != 8'h8B |=> execStart)
      else $error("plain command not started");
   a_sleep_stays: assert property (sleeping && !softReset && !$past(softReset) |=> sleeping)
      else $error("sleep left without reset");
   a_sleep_quiet: assert property (sleeping |=> !execStart)
      else $error("command started while asleep");
   a_abort_sleep: assert property (
      roleSleep && busy && !sleeping && !firstInit && !softReset
      && $fell(protect_or_sleep_pin_n) |-> ##[1:4] sleeping)
      else $error("pin did not force sleep");
   a_role_cause: assert property (
      $changed(roleSleep) |-> $past(cause, 1) || $past(cause, 2) || $past(cause, 3))
      else $error("role changed without select");
   a_first_busy: assert property (firstInit |-> busy)
      else $error("first init not busy");
   a_wake_reset: assert property (($rose(resetn) || $fell(softReset)) |=> !sleeping)
      else $error("reset did not wake");
endmodule // wppd_gate_asserts
bind wppd_gate wppd_gate_asserts i_chk (.sys_clk, .resetn, .softReset, .protect_or_sleep_pin_n,
   .cmdValid, .cmdCode, .busy, .execStart, .cmdDone, .statusOut, .errorOut, .sleeping,
   .roleSleep, .firstInit);
`default_nettype wire

// ---- testbench/wppd_host_model.sv ----
// host model: issues commands and drives the shared pin
// assumes changes at the falling edge of sys_clk
`timescale 1ns/10ps
`default_nettype none
module wppd_host_model (
   // clock and answer
   input wire logic sys_clk,
   input wire logic busy,
   // command lines
   output logic cmdValid,
   output logic [7:0] cmdCode,
   output logic [7:0] cmdFeature,
   output logic [31:0] cmdLba,
   // pin
   output logic protect_or_sleep_pin_n
);
   // ----
   // host side
   // ----
   initial begin
      cmdValid = 1'b0;
      cmdCode = 8'h00;
      cmdFeature = 8'h00;
      cmdLba = 32'h0;
      protect_or_sleep_pin_n = 1'b1;
   end
   // one command; waits for idle unless told to push it anyway
   task automatic issue(input logic [7:0] c, input logic [7:0] f, input logic [31:0] a,
      input logic skipWait);
      int n;
      n = 0;
      @(negedge sys_clk);
      while (busy !== 1'b0 && !skipWait && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      cmdValid = 1'b1;
      cmdCode = c;
      cmdFeature = f;
      cmdLba = a;
      @(negedge sys_clk);
      cmdValid = 1'b0;
      cmdCode = ~c;
      cmdFeature = ~f;
      cmdLba = ~a;
   endtask
   // pin settles well before the next command
   task automatic setPin(input logic low);
      @(negedge sys_clk);
      protect_or_sleep_pin_n = !low;
      repeat (3) @(negedge sys_clk);
   endtask
endmodule // wppd_host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for wppd_gate
// assumes the host model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // ----
   // bench
   // ----
   logic sys_clk, resetn, softReset, powerOn, execDone, zoneWrite, busy, execStart, cmdDone;
   logic sleeping, roleSleep, cmdValid, protect_or_sleep_pin_n;
   logic zoneOn, execAbort, firstInit, aborted;
   logic [7:0] cmdCode, cmdFeature, statusOut, errorOut, code;
   logic [31:0] cmdLba;
   logic [15:0] rnd;
   int fail_count, comparisons, cyc, n, ex;
   logic [7:0] destr [8] = '{8'hC0, 8'h50, 8'hCA, 8'hCB, 8'hC5, 8'h30, 8'h31, 8'h3C};
   wppd_gate #(.FIRST_BUSY_CYCLES(20)) i_dut (.sys_clk, .resetn, .softReset, .powerOn,
      .initDoneStrap(1'b0), .protect_or_sleep_pin_n, .cmdValid, .cmdCode, .cmdFeature,
      .cmdLba, .execDone, .initDone(1'b0), .zoneWrite, .zoneIdx(rnd[1:0]), .zoneEnable(zoneOn),
      .zoneHidden(zoneOn), .zoneStart({2{rnd}}), .zoneEnd({2{rnd}}), .zonePassword({2{rnd}}),
      .pwdValid(zoneWrite), .pwdValue({2{rnd}}), .busy, .execStart, .execAbort,
      .cmdDone, .statusOut, .errorOut, .sleeping, .roleSleep, .firstInit);
   wppd_host_model i_host (.sys_clk, .busy, .cmdValid, .cmdCode, .cmdFeature, .cmdLba,
      .protect_or_sleep_pin_n);
   function automatic logic [15:0] nextRnd(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] expAns(input logic [7:0] c, input logic low);
      return (low && c inside {destr}) ? 16'h5104 : 16'h5000;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic waitFor(ref logic s);
      n = 0;
      while (s !== 1'b1 && n < 60) begin
         @(negedge sys_clk);
         n++;
      end
   endtask
   task automatic hardReset();
      @(negedge sys_clk);
      resetn = 1'b0;
      repeat (2) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (3) @(negedge sys_clk);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // backend finishes a started command after a random delay
   always @(negedge sys_clk) begin
      rnd <= nextRnd(rnd);
      execDone <= (ex == 1);
      ex <= (execStart === 1'b1) ? rnd[1:0] + 6 : (ex > 0) ? ex - 1 : 0;
      cyc <= cyc + 1;
      if (execAbort === 1'b1) aborted <= 1'b1;
      if (cyc > 3000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      {rnd, cyc, ex, fail_count, comparisons} = {16'd13946, 128'd0};
      {resetn, softReset, powerOn, execDone, zoneWrite, zoneOn, aborted} = 7'b0010000;
      @(negedge sys_clk);
      powerOn = 1'b0;
      repeat (4) @(negedge sys_clk);
      resetn = 1'b1;
      n = 0;
      while (busy !== 1'b0 && n < 60) begin
         @(negedge sys_clk);
         n++;
      end
      check(n >= 19 && n <= 25, 1);
      check(roleSleep, 1'b0);
      zoneWrite = 1'b1;
      @(negedge sys_clk);
      zoneWrite = 1'b0;
      hardReset();
      check(busy, 1'b0);
      check(firstInit, 1'b0);
      for (int p = 0; p < 2; p++) begin
         i_host.setPin(p == 0);
         for (int i = 0; i < 10; i++) begin
            code = (i < 8) ? destr[i[2:0]] : rnd[7:0] inside {destr, 8'h8B} ? 8'h20 : rnd[7:0];
            i_host.issue(code, rnd[7:0], {2{rnd}}, 1'b0);
            waitFor(cmdDone);
            check({statusOut, errorOut}, expAns(code, p == 0));
         end
      end
      i_host.issue(wppd_pkg::CMD_ROLE_SELECT, wppd_pkg::FEAT_POWERDOWN, 32'h0, 1'b0);
      waitFor(cmdDone);
      @(negedge sys_clk);
      check(roleSleep, 1'b1);
      hardReset();
      check(roleSleep, 1'b1);
      i_host.issue(8'h20, 8'h00, 32'h0, 1'b0);
      waitFor(execStart);
      i_host.setPin(1'b1);
      waitFor(sleeping);
      check(sleeping, 1'b1);
      check(aborted, 1'b1);
      i_host.issue(8'h20, 8'h00, 32'h0, 1'b1);
      repeat (12) @(negedge sys_clk);
      check(sleeping, 1'b1);
      i_host.setPin(1'b0);
      softReset = 1'b1;
      @(negedge sys_clk);
      softReset = 1'b0;
      repeat (3) @(negedge sys_clk);
      check({sleeping, roleSleep}, 2'b01);
      i_host.issue(wppd_pkg::CMD_ROLE_SELECT, wppd_pkg::FEAT_PROTECT, 32'h0, 1'b0);
      waitFor(cmdDone);
      @(negedge sys_clk);
      check(roleSleep, 1'b0);
      summarize();
   end
endmodule // tb_top
`default_nettype wire
